// >>> crwl_lock.sv
// How it works
// - Five lock registers each protect their own region of the configuration space.
// - A write into a locked region is dropped and the region's contents stay unchanged.
// - A lock register locks only on its lock key and unlocks only on its distinct unlock key.
// - The fifth lock register reads 0x143F832C when locked and 0x6F361E05 unlocks it.
// - Writing 0x143F832C to the fifth lock register locks the fifth region.
// - A write to the locked fifth region returns a bus error instead of being dropped quietly.
// - After that error every later access to any register is blocked until reset.
`timescale 1ns/1ns
`default_nettype none
module crwl_lock (
  input  wire logic               i_mclk,
  input  wire logic               i_reset,
  input  wire crwl_pkg::crwl_req_t i_req,
  output var  crwl_pkg::crwl_rsp_t o_rsp,
  output logic [crwl_pkg::NUM_REGIONS-1:0] o_locked,
  output logic                    o_blocked
);
  localparam int unsigned NR = crwl_pkg::NUM_REGIONS;
  localparam int unsigned NW = crwl_pkg::WORDS_PER_REGION;

  logic [NR-1:0]                  locked;
  logic                           blocked;
  logic [crwl_pkg::DATA_W-1:0]    cfg [NR*NW];
  logic [NR-1:0]                  lock_hit;
  logic                           in_region;
  logic [crwl_pkg::REGION_W-1:0]  ridx;
  logic [1:0]                     widx;
  logic                           wr_lock;
  logic                           err_write;
  logic [crwl_pkg::ADDR_W-1:0]    roff;

  always_comb begin
    roff      = i_req.addr - crwl_pkg::REGION_BASE;
    in_region = (i_req.addr >= crwl_pkg::REGION_BASE) &&
                (roff[crwl_pkg::ADDR_W-1:crwl_pkg::REGION_SHIFT] < crwl_pkg::ADDR_W'(NR));
    ridx      = roff[crwl_pkg::REGION_SHIFT+:crwl_pkg::REGION_W];
    widx      = roff[3:2];
  end

  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_lock
      assign lock_hit[g] = (i_req.addr == crwl_pkg::LOCK_BASE +
                            crwl_pkg::ADDR_W'(g) * crwl_pkg::LOCK_STRIDE);
      // Accesses are refused once blocked, so keys have no effect then
      always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          locked[g] <= crwl_pkg::LOCK_RESET;
        end else if (i_req.valid && i_req.write && !blocked && lock_hit[g]) begin
          if (i_req.wdata == crwl_pkg::LOCK_KEYS[g]) begin
            locked[g] <= 1'b1;
          end else if (i_req.wdata == crwl_pkg::UNLOCK_KEYS[g]) begin
            locked[g] <= 1'b0;
          end
          // Any other value keeps the state
        end
      end
    end
  endgenerate

  assign wr_lock   = i_req.valid && i_req.write && in_region && !blocked;
  assign err_write = wr_lock && locked[ridx] && (ridx == crwl_pkg::FIFTH_IDX);

  // Region storage has no reset; contents are software-owned configuration
  always_ff @(posedge i_mclk) begin
    if (wr_lock && !locked[ridx]) begin
      cfg[ridx*NW + widx] <= i_req.wdata;
    end
  end

  // The faulty silicon wedges the whole module; kept so software sees the same hang
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      blocked <= 1'b0;
    end else if (err_write) begin
      blocked <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= i_req.valid && !blocked;
      o_rsp.error <= err_write;
      o_rsp.rdata <= crwl_pkg::UNLOCKED_READ;
      if (i_req.valid && !i_req.write && !blocked) begin
        for (int i = 0; i < NR; i++) begin
          if (lock_hit[i] && locked[i]) begin
            o_rsp.rdata <= crwl_pkg::LOCK_KEYS[i];
          end
        end
        if (in_region) begin
          o_rsp.rdata <= cfg[ridx*NW + widx];
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_locked  <= '0;
      o_blocked <= 1'b0;
    end else begin
      o_locked  <= locked;
      o_blocked <= blocked;
    end
  end

  a_lock_key_sets: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_req.valid && i_req.write && !blocked && lock_hit[4] &&
     i_req.wdata == crwl_pkg::LOCK_KEYS[4]) |=> locked[4])
    else $error("lock key did not lock");
  a_unlock_key_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_req.valid && i_req.write && !blocked && lock_hit[4] &&
     i_req.wdata == crwl_pkg::UNLOCK_KEYS[4]) |=> !locked[4])
    else $error("unlock key did not unlock");
  a_other_value_holds: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_req.valid && i_req.write && lock_hit[0] &&
     i_req.wdata != crwl_pkg::LOCK_KEYS[0] && i_req.wdata != crwl_pkg::UNLOCK_KEYS[0])
    |=> $stable(locked[0]))
    else $error("lock state changed on a non-key write");
  a_locked_read_key: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_req.valid && !i_req.write && !blocked && lock_hit[4] && locked[4])
    |=> o_rsp.valid && o_rsp.rdata == 32'h143F_832C)
    else $error("locked fifth register read wrong value");
  a_locked_write_err: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_lock && ridx == crwl_pkg::FIFTH_IDX && locked[4]) |=> o_rsp.error && o_rsp.valid)
    else $error("no error on locked fifth region write");
  // A request taken in the same cycle as the error already gets no answer; the valid check only starts two cycles later
  a_block_sticks: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_rsp.error |-> blocked ##1 blocked ##1 (blocked && !o_rsp.valid)[*3])
    else $error("access not blocked after error");
  a_blocked_stays: assert property (@(posedge i_mclk) disable iff (i_reset)
    blocked |=> blocked && o_blocked)
    else $error("blocked state released without reset");
  a_answer_follows: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_req.valid && !blocked) |=> o_rsp.valid)
    else $error("accepted request got no answer");
  a_error_fifth_only: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_rsp.error |-> o_rsp.valid && blocked)
    else $error("error answer without fifth region fault");
  a_locked_write_drop: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_lock && locked[ridx] && ridx != crwl_pkg::FIFTH_IDX) |=> !o_rsp.error && !blocked)
    else $error("locked write to other region misbehaved");
  a_outputs_follow: assert property (@(posedge i_mclk) disable iff (i_reset)
    ##1 o_locked == $past(locked))
    else $error("lock outputs lag wrongly");
endmodule
`default_nettype wire

// >>> crwl_pkg.sv
`default_nettype none
package crwl_pkg;
  localparam int unsigned NUM_REGIONS = 5;
  localparam int unsigned REGION_W    = 3;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;

  // Lock register offsets, one per region, followed by region windows
  localparam logic [ADDR_W-1:0] LOCK_BASE   = 12'h0_000;
  localparam logic [ADDR_W-1:0] LOCK_STRIDE = 12'h0_004;
  // Each region spans 256 bytes; region n sits at REGION_BASE + (n << REGION_SHIFT)
  localparam logic [ADDR_W-1:0] REGION_BASE = 12'h0_100;
  localparam int unsigned       REGION_SHIFT = 8;
  localparam logic [REGION_W-1:0] FIFTH_IDX  = 3'h4;
  localparam int unsigned       WORDS_PER_REGION = 4;

  typedef logic [DATA_W-1:0] crwl_key_t;
  typedef crwl_key_t [NUM_REGIONS-1:0] crwl_keys_t;

  // Lock and unlock keys; regions 0..3 use arbitrary distinct values
  localparam crwl_keys_t LOCK_KEYS = '{32'h143F_832C, 32'h1111_0004, 32'h1111_0003,
                                       32'h1111_0002, 32'h1111_0001};
  localparam crwl_keys_t UNLOCK_KEYS = '{32'h6F36_1E05, 32'h2222_0004, 32'h2222_0003,
                                         32'h2222_0002, 32'h2222_0001};
  localparam crwl_key_t UNLOCKED_READ = 32'h0000_0000;
  localparam logic      LOCK_RESET   = 1'b0;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } crwl_req_t;

  typedef struct packed {
    logic              valid;
    logic              error;
    logic [DATA_W-1:0] rdata;
  } crwl_rsp_t;
endpackage
`default_nettype wire

// >>> crwl_init.sv
`timescale 1ns/1ns
`default_nettype none
module crwl_init (
  input  wire crwl_pkg::crwl_rsp_t i_rsp,
  input  wire logic                i_mclk,
  output var  crwl_pkg::crwl_req_t o_req
);
  initial o_req = '0;
  // Idle lines carry inverted values so stale data never passes for a request
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output crwl_pkg::crwl_rsp_t r);
    @(posedge i_mclk);
    #1 o_req = {1'b1, w, a, d};
    @(posedge i_mclk);
    #1 o_req = {1'b0, ~w, ~a, ~d};
    r = i_rsp;
  endtask
endmodule
`default_nettype wire

// >>> crwl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module crwl_bench;
  logic                i_mclk;
  logic                i_reset;
  crwl_pkg::crwl_req_t req;
  crwl_pkg::crwl_rsp_t rsp;
  crwl_pkg::crwl_rsp_t r;
  logic [4:0]          locked;
  logic                blocked;
  int                  err_count;
  int                  n_compared;
  crwl_lock i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_req(req), .o_rsp(rsp),
                   .o_locked(locked), .o_blocked(blocked));
  crwl_init i_ini (.i_rsp(rsp), .i_mclk(i_mclk), .o_req(req));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    i_reset = 1'b1;
    repeat (20) @(posedge i_mclk);
    #1 i_reset = 1'b0;
    chk({blocked, locked}, 32'h0000_0000);
  endtask
  // Regions 0..3 drop locked writes quietly and keep their old data
  task automatic t_regions;
    logic [11:0] ra;
    logic [11:0] la;
    for (int n = 0; n < 4; n++) begin
      ra = 12'((n + 1) << 8);
      la = 12'(n * 4);
      i_ini.acc(1'b1, ra, 32'hA5A5_0000 + n, r);
      i_ini.acc(1'b1, la, 32'h0000_0001, r);
      i_ini.acc(1'b0, la, 32'h0000_0000, r);
      chk({r.rdata, locked[n]}, 33'h0_0000_0000);
      i_ini.acc(1'b1, la, crwl_pkg::LOCK_KEYS[n], r);
      i_ini.acc(1'b1, la, crwl_pkg::LOCK_KEYS[n], r);
      i_ini.acc(1'b0, la, 32'h0000_0000, r);
      chk({r.rdata, locked[n]}, {crwl_pkg::LOCK_KEYS[n], 1'b1});
      i_ini.acc(1'b1, ra, 32'hDEAD_0000, r);
      chk({r.valid, r.error}, 32'h0000_0002);
      i_ini.acc(1'b0, ra, 32'h0000_0000, r);
      chk(r.rdata, 32'hA5A5_0000 + n);
      i_ini.acc(1'b1, la, crwl_pkg::UNLOCK_KEYS[n], r);
      i_ini.acc(1'b0, la, 32'h0000_0000, r);
      chk({r.rdata, locked}, 32'h0000_0000);
    end
  endtask
  task automatic t_fifth;
    i_ini.acc(1'b1, 12'h010, 32'h143F_832C, r);
    i_ini.acc(1'b0, 12'h010, 32'h0000_0000, r);
    chk({r.rdata, locked}, {32'h143F_832C, 5'h10});
    i_ini.acc(1'b1, 12'h010, 32'h6F36_1E05, r);
    i_ini.acc(1'b1, 12'h500, 32'h1234_5678, r);
    chk({r.valid, r.error, locked[4]}, 32'h0000_0004);
    i_ini.acc(1'b1, 12'h010, 32'h143F_832C, r);
    i_ini.acc(1'b0, 12'h500, 32'h0000_0000, r);
    chk(r.rdata, 32'h1234_5678);
    i_ini.acc(1'b1, 12'h500, 32'h0000_0000, r);
    chk({r.valid, r.error}, 32'h0000_0003);
    i_ini.acc(1'b0, 12'h010, 32'h0000_0000, r);
    chk({r.valid, blocked}, 32'h0000_0001);
  endtask
  initial begin
    #50_000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    err_count = 0;
    n_compared = 0;
    do_reset();
    t_regions();
    t_fifth();
    do_reset();
    t_fifth();
    tally_and_finish();
  end
endmodule
`default_nettype wire
